// File: inc/bvm_defs.svh
// register map, field positions, reset values and timing counts of the monitor block
`ifndef BVM_DEFS_SVH
`define BVM_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define BVM_IDX_DETECTOR_MODE_CONTROL 6'h00
`define BVM_IDX_DETECTOR_THRESHOLD_CODE 6'h01
`define BVM_IDX_MONITOR_LEVEL_CONTROL 6'h08
`define BVM_IDX_MONITOR_INTERRUPT_CONTROL 6'h09
`define BVM_IDX_MONITOR_INTERRUPT_FLAGS 6'h0a
`define BVM_IDX_MONITOR_STATUS 6'h0b

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BVM_RATE_BIT 4
`define BVM_RUN_MODE_HI 3
`define BVM_RUN_MODE_LO 2
`define BVM_SLEEP_MODE_HI 1
`define BVM_SLEEP_MODE_LO 0
`define BVM_TRIG_HI 2
`define BVM_TRIG_LO 1
`define BVM_IE_BIT 0
`define BVM_FLAG_BIT 0
`define BVM_STATUS_BIT 0
`define BVM_FUSE_LVL_HI 7
`define BVM_FUSE_LVL_LO 5

// ------------------------------------------------------------
// reset values of the software registers
// ------------------------------------------------------------
`define BVM_RST_LEVEL_CTRL 2'h0
`define BVM_RST_IRQ_CTRL 3'h0
`define BVM_RST_FLAGS 1'h0
`define BVM_RST_STATUS 1'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BVM_MCLK_KHZ 10000
`define BVM_PERIOD_FAST_US 1000
`define BVM_PERIOD_SLOW_US 8000
`define BVM_FAST_CYC (`BVM_PERIOD_FAST_US * `BVM_MCLK_KHZ / 1000)
`define BVM_SLOW_CYC (`BVM_PERIOD_SLOW_US * `BVM_MCLK_KHZ / 1000)
`define BVM_CCP_WINDOW 3'h4

`endif

// File: inc/bvm_pkg.sv
// types shared by the monitor block modules
package bvm_pkg;

  // detector operating modes, in register code order
  typedef enum logic [1:0] {
    BVM_MODE_OFF,
    BVM_MODE_CONT,
    BVM_MODE_SAMPLED,
    BVM_MODE_CONT_HOLD
  } bvm_mode_t;

  // monitor trigger selections, in register code order
  typedef enum logic [1:0] {
    BVM_TRIG_BELOW,
    BVM_TRIG_ABOVE,
    BVM_TRIG_CROSS,
    BVM_TRIG_RSVD
  } bvm_trig_t;

endpackage

// File: inc/bvm_mon_if.sv
// signals shared between the control core, the sampler and the level watcher
`timescale 1ns/1ps
`default_nettype none

interface bvm_mon_if;
  import bvm_pkg::*;
  bvm_mode_t det_mode;
  logic rate_slow;
  logic sample_tick;
  bvm_trig_t trig_sel;
  logic below;
  logic trig_event;

  modport core (output det_mode, output rate_slow, output trig_sel,
                input sample_tick, input below, input trig_event);
  modport sampler (input det_mode, input rate_slow, output sample_tick);
  modport watch (input det_mode, input sample_tick, input trig_sel,
                 output below, output trig_event);
endinterface

`default_nettype wire

// File: rtl/bvm_sampler.sv
// sample-rate divider: one-cycle tick per detector sample in sampled mode
`timescale 1ns/1ps
`default_nettype none

`include "bvm_defs.svh"

module bvm_sampler
  import bvm_pkg::*;
#(
  parameter logic [16:0] FAST_CYC = 17'(`BVM_FAST_CYC),
  parameter logic [16:0] SLOW_CYC = 17'(`BVM_SLOW_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  bvm_mon_if.sampler mon
);

  logic [16:0] count;
  logic [16:0] period;

  // period follows the rate bit: 1 kHz when clear, 125 Hz when set
  assign period = mon.rate_slow ? SLOW_CYC : FAST_CYC;

  // free count while sampled; the compare uses >= so a rate change never overruns
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= 17'h00000;
      mon.sample_tick <= 1'b0;
    end else if (mon.det_mode != BVM_MODE_SAMPLED) begin
      count <= 17'h00000;
      mon.sample_tick <= 1'b0;
    end else if (count >= period - 17'h00001) begin
      count <= 17'h00000;
      mon.sample_tick <= 1'b1;
    end else begin
      count <= count + 17'h00001;
      mon.sample_tick <= 1'b0;
    end
  end

endmodule // bvm_sampler

`default_nettype wire

// File: rtl/bvm_level_watch.sv
// synchronises the comparator, holds the below status and finds trigger events
`timescale 1ns/1ps
`default_nettype none

module bvm_level_watch
  import bvm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic supply_below_pin,
  bvm_mon_if.watch mon
);

  logic sync_a;
  logic sync_b;
  logic update;

  // two-stage synchroniser on the analog comparator output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= supply_below_pin;
      sync_b <= sync_a;
    end
  end

  // monitor follows the detector: off holds, sampled takes ticks only
  always_comb begin
    case (mon.det_mode)
      BVM_MODE_OFF: update = 1'b0;
      BVM_MODE_SAMPLED: update = mon.sample_tick;
      default: update = 1'b1;
    endcase
  end

  // status is one while below the threshold; held stale when disabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mon.below <= 1'b0;
    end else if (update) begin
      mon.below <= sync_b;
    end
  end

  // event pulse on a crossing that matches the trigger selection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mon.trig_event <= 1'b0;
    end else if (update && (sync_b != mon.below)) begin
      case (mon.trig_sel)
        BVM_TRIG_BELOW: mon.trig_event <= sync_b;
        BVM_TRIG_ABOVE: mon.trig_event <= ~sync_b;
        BVM_TRIG_CROSS: mon.trig_event <= 1'b1;
        default: mon.trig_event <= 1'b0;
      endcase
    end else begin
      mon.trig_event <= 1'b0;
    end
  end

endmodule // bvm_level_watch

`default_nettype wire

// File: rtl/bvm_ctrl_regs.sv
// supply dropout detector and early warning monitor: APB registers and control
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "bvm_defs.svh"

module bvm_ctrl_regs
  import bvm_pkg::*;
#(
  parameter logic [16:0] FAST_CYC = 17'(`BVM_FAST_CYC),
  parameter logic [16:0] SLOW_CYC = 17'(`BVM_SLOW_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuse contents, static after power-up
  input wire logic [7:0] detector_config_fuse,
  // cpu side pulses and the deep-sleep level on this clock
  input wire logic config_change_unlock,
  input wire logic instr_retired,
  input wire logic deep_sleep,
  // analog side pins
  input wire logic supply_below_pin,
  input wire logic detector_ready_pin,
  // towards the analog block and the core
  output logic [1:0] detector_mode,
  output logic detector_sample_strobe,
  output logic [2:0] threshold_code,
  output logic [1:0] monitor_margin_select,
  output logic monitor_active,
  output logic exec_hold,
  output logic supply_early_warning_irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic fuse_pending;
  logic sample_rate_select;
  bvm_mode_t run_mode;
  bvm_mode_t sleep_mode;
  logic [2:0] threshold_reg;
  logic [1:0] margin_reg;
  bvm_trig_t trig_reg;
  logic monitor_irq_enable;
  logic monitor_irq_flag;
  logic [2:0] unlock_left;
  logic ready_a;
  logic ready_b;
  logic sleep_prev;
  bvm_mode_t next_mode;

  logic [5:0] reg_idx;
  logic wr_en;
  logic rd_setup;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  bvm_mon_if mon ();

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // zero wait states: read data is captured in the setup cycle so it can
  // come from a flip-flop and still be ready in the access cycle
  assign reg_idx = paddr[7:2];
  assign pready = 1'b1;
  assign pslverr = 1'b0; // reserved space answers with zero, not an error
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte = pwdata[7:0];

  // read multiplexer; anything unlisted reads zero
  always_comb begin
    rd_byte = 8'h00;
    case (reg_idx)
      `BVM_IDX_DETECTOR_MODE_CONTROL: begin
        rd_byte[`BVM_RATE_BIT] = sample_rate_select;
        rd_byte[`BVM_RUN_MODE_HI:`BVM_RUN_MODE_LO] = run_mode;
        rd_byte[`BVM_SLEEP_MODE_HI:`BVM_SLEEP_MODE_LO] = sleep_mode;
      end
      `BVM_IDX_DETECTOR_THRESHOLD_CODE: begin
        rd_byte[2:0] = threshold_reg;
      end
      `BVM_IDX_MONITOR_LEVEL_CONTROL: begin
        rd_byte[1:0] = margin_reg;
      end
      `BVM_IDX_MONITOR_INTERRUPT_CONTROL: begin
        rd_byte[`BVM_TRIG_HI:`BVM_TRIG_LO] = trig_reg;
        rd_byte[`BVM_IE_BIT] = monitor_irq_enable;
      end
      `BVM_IDX_MONITOR_INTERRUPT_FLAGS: begin
        rd_byte[`BVM_FLAG_BIT] = monitor_irq_flag;
      end
      `BVM_IDX_MONITOR_STATUS: begin
        rd_byte[`BVM_STATUS_BIT] = mon.below;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // registered read data, upper bits always zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // fuse load
  // ------------------------------------------------------------
  // the fuse is a level, so it is caught by a clocked load in the first
  // cycle after reset release rather than by the asynchronous reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fuse_pending <= 1'b1;
    end else begin
      fuse_pending <= 1'b0;
    end
  end

  // rate bit and run mode: fuse loaded, never written by software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sample_rate_select <= 1'b0;
      run_mode <= BVM_MODE_OFF;
      threshold_reg <= 3'h0;
    end else if (fuse_pending) begin
      sample_rate_select <= detector_config_fuse[`BVM_RATE_BIT];
      run_mode <= bvm_mode_t'(detector_config_fuse[`BVM_RUN_MODE_HI:`BVM_RUN_MODE_LO]);
      threshold_reg <= detector_config_fuse[`BVM_FUSE_LVL_HI:`BVM_FUSE_LVL_LO];
    end
  end
  // bus writes never reach the read-only fields, so no unlock applies

  // ------------------------------------------------------------
  // configuration change unlock window
  // ------------------------------------------------------------
  // the key opens a window of four retired instructions; a fresh key
  // restarts it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      unlock_left <= 3'h0;
    end else if (config_change_unlock) begin
      unlock_left <= `BVM_CCP_WINDOW;
    end else if (instr_retired && unlock_left != 3'h0) begin
      unlock_left <= unlock_left - 3'h1;
    end
  end

  // deep-sleep mode: fuse loaded, then writable only inside the window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_mode <= BVM_MODE_OFF;
    end else if (fuse_pending) begin
      sleep_mode <= bvm_mode_t'(detector_config_fuse[`BVM_SLEEP_MODE_HI:`BVM_SLEEP_MODE_LO]);
    end else if (wr_en && reg_idx == `BVM_IDX_DETECTOR_MODE_CONTROL && unlock_left != 3'h0) begin
      sleep_mode <= bvm_mode_t'(wbyte[`BVM_SLEEP_MODE_HI:`BVM_SLEEP_MODE_LO]);
    end
  end

  // ------------------------------------------------------------
  // monitor configuration registers
  // ------------------------------------------------------------
  // margin code goes straight to the analog threshold ladder
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      margin_reg <= `BVM_RST_LEVEL_CTRL;
    end else if (wr_en && reg_idx == `BVM_IDX_MONITOR_LEVEL_CONTROL) begin
      margin_reg <= wbyte[1:0];
    end
  end

  // trigger selection and interrupt enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trig_reg <= BVM_TRIG_BELOW;
      monitor_irq_enable <= 1'b0;
    end else if (wr_en && reg_idx == `BVM_IDX_MONITOR_INTERRUPT_CONTROL) begin
      trig_reg <= bvm_trig_t'(wbyte[`BVM_TRIG_HI:`BVM_TRIG_LO]);
      monitor_irq_enable <= wbyte[`BVM_IE_BIT];
    end
  end

  // ------------------------------------------------------------
  // monitor flag
  // ------------------------------------------------------------
  // a trigger in the same cycle as a clear keeps the flag set; events
  // only arrive while the detector runs, so a disabled detector holds it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      monitor_irq_flag <= `BVM_RST_FLAGS;
    end else if (mon.trig_event) begin
      monitor_irq_flag <= 1'b1;
    end else if (wr_en && reg_idx == `BVM_IDX_MONITOR_INTERRUPT_FLAGS
                 && wbyte[`BVM_FLAG_BIT]) begin
      monitor_irq_flag <= 1'b0;
    end
  end

  // request stands until software clears the flag or the enable
  assign supply_early_warning_irq = monitor_irq_enable & monitor_irq_flag;

  // ------------------------------------------------------------
  // mode selection across sleep
  // ------------------------------------------------------------
  // deep sleep picks the deep-sleep field; reserved code 3 runs as off
  always_comb begin
    if (fuse_pending) begin
      next_mode = BVM_MODE_OFF;
    end else if (deep_sleep) begin
      case (sleep_mode)
        BVM_MODE_CONT: next_mode = BVM_MODE_CONT;
        BVM_MODE_SAMPLED: next_mode = BVM_MODE_SAMPLED;
        default: next_mode = BVM_MODE_OFF;
      endcase
    end else begin
      next_mode = run_mode;
    end
  end

  // effective mode register feeds the analog block and the monitor
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mon.det_mode <= BVM_MODE_OFF;
    end else begin
      mon.det_mode <= next_mode;
    end
  end

  // ------------------------------------------------------------
  // wake hold
  // ------------------------------------------------------------
  // detector ready comes from the analog side, so it is synchronised
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready_a <= 1'b0;
      ready_b <= 1'b0;
    end else begin
      ready_a <= detector_ready_pin;
      ready_b <= ready_a;
    end
  end

  // remembers the last sleep level to find the wake edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_prev <= 1'b0;
    end else begin
      sleep_prev <= deep_sleep;
    end
  end

  // with run mode BVM_MODE_CONT_HOLD, execution is held from wake until the detector reports running;
  // a wake edge beats a ready seen in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exec_hold <= 1'b0;
    end else if (sleep_prev && !deep_sleep && run_mode == BVM_MODE_CONT_HOLD) begin
      exec_hold <= 1'b1;
    end else if (ready_b) begin
      exec_hold <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // analog controls are copied out of flip-flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      threshold_code <= 3'h0;
      monitor_margin_select <= 2'h0;
      monitor_active <= 1'b0;
    end else begin
      threshold_code <= threshold_reg;
      monitor_margin_select <= margin_reg;
      monitor_active <= monitor_irq_enable & (next_mode != BVM_MODE_OFF);
    end
  end

  assign detector_mode = mon.det_mode;
  assign detector_sample_strobe = mon.sample_tick;

  // ------------------------------------------------------------
  // monitor plumbing
  // ------------------------------------------------------------
  assign mon.rate_slow = sample_rate_select;
  assign mon.trig_sel = trig_reg;

  // sample divider, long counts shortened through the parameters
  bvm_sampler #(
    .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) u_sampler (
    .mclk(mclk),
    .rst(rst),
    .mon(mon.sampler)
  );

  // comparator synchroniser and event finder
  bvm_level_watch u_watch (
    .mclk(mclk),
    .rst(rst),
    .supply_below_pin(supply_below_pin),
    .mon(mon.watch)
  );

endmodule // bvm_ctrl_regs

`default_nettype wire

// File: bench/bvm_ctrl_regs_asserts.sv
// port-level checks of the monitor register block
`timescale 1ns/1ps
`default_nettype none

module bvm_ctrl_regs_asserts #(
  parameter logic [16:0] FAST_CYC = 17'h00008,
  parameter logic [16:0] SLOW_CYC = 17'h00040
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] detector_config_fuse,
  input wire logic deep_sleep,
  input wire logic detector_ready_pin,
  input wire logic [1:0] detector_mode,
  input wire logic detector_sample_strobe,
  input wire logic [2:0] threshold_code,
  input wire logic monitor_active,
  input wire logic exec_hold,
  input wire logic supply_early_warning_irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [1:0] up_cnt;
  logic [16:0] gap;
  logic gap_ok;
  wire logic settled = up_cnt == 2'h3;
  // clearing the enable drops the request as legally as clearing the flag
  wire logic irq_wr = psel && penable && pwrite && pstrb[0] &&
                      (paddr == 8'h24 || paddr[7:3] == 5'h05);
  // fuse fields settle two edges after release, so wait three
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) up_cnt <= 2'h0;
    else if (!settled) up_cnt <= up_cnt + 2'h1;
  end
  // strobe spacing is only meaningful while sampled mode stays put
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gap <= 17'h0;
      gap_ok <= 1'b0;
    end else if (detector_sample_strobe) begin
      gap <= 17'h1;
      gap_ok <= detector_mode == 2'h2;
    end else begin
      gap <= gap + 17'h1;
      if (detector_mode != 2'h2) gap_ok <= 1'b0;
    end
  end
  property p_bus_answer;
    @(posedge mclk) disable iff (rst) psel && penable && !pwrite |-> pready && prdata[31:8] == 24'h0;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bad read answer");
  property p_thr;
    @(posedge mclk) disable iff (rst) settled |-> threshold_code == detector_config_fuse[7:5];
  endproperty
  a_thr: assert property (p_thr) else $error("threshold code differs from fuse");
  property p_run;
    @(posedge mclk) disable iff (rst)
      settled && !deep_sleep && !$past(deep_sleep) && !$past(deep_sleep, 2)
      |-> detector_mode == detector_config_fuse[3:2];
  endproperty
  a_run: assert property (p_run) else $error("awake mode differs from fuse");
  property p_sleep_code;
    @(posedge mclk) disable iff (rst) deep_sleep && $past(deep_sleep) |-> detector_mode != 2'h3;
  endproperty
  a_sleep_code: assert property (p_sleep_code) else $error("sleep mode shows hold code");
  property p_off_quiet;
    @(posedge mclk) disable iff (rst) detector_mode == 2'h0 ##1 detector_mode == 2'h0 |-> !monitor_active;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("monitor active while off");
  property p_rate;
    @(posedge mclk) disable iff (rst)
      detector_sample_strobe && gap_ok |-> gap == (detector_config_fuse[4] ? SLOW_CYC : FAST_CYC);
  endproperty
  a_rate: assert property (p_rate) else $error("sample spacing wrong");
  property p_irq_holds;
    @(posedge mclk) disable iff (rst) supply_early_warning_irq && !irq_wr |=> supply_early_warning_irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped without clear");
  property p_frozen;
    @(posedge mclk) disable iff (rst)
      (detector_mode == 2'h0)[*4] ##0 (!supply_early_warning_irq && !irq_wr) |=> !supply_early_warning_irq;
  endproperty
  a_frozen: assert property (p_frozen) else $error("flag moved while off");
  property p_hold_rel;
    @(posedge mclk) disable iff (rst) detector_ready_pin [*5] |-> !exec_hold;
  endproperty
  a_hold_rel: assert property (p_hold_rel) else $error("hold kept after ready");
endmodule // bvm_ctrl_regs_asserts

bind bvm_ctrl_regs bvm_ctrl_regs_asserts #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) u_chk (
  .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .detector_config_fuse(detector_config_fuse),
  .deep_sleep(deep_sleep), .detector_ready_pin(detector_ready_pin), .detector_mode(detector_mode),
  .detector_sample_strobe(detector_sample_strobe), .threshold_code(threshold_code),
  .monitor_active(monitor_active), .exec_hold(exec_hold),
  .supply_early_warning_irq(supply_early_warning_irq));

`default_nettype wire

// File: bench/bvm_analog_model.sv
// behavioural supply comparator and detector start-up on the analog side
`timescale 1ns/1ps
`default_nettype none

module bvm_analog_model #(
  parameter int RDY_DLY = 20
) (
  input wire logic mclk,
  input wire logic deep_sleep,
  input wire logic supply_low,
  output logic supply_below_pin,
  output logic detector_ready_pin
);
  int cnt = 0;
  // comparator is high while the supply sits under the monitor threshold
  assign supply_below_pin = supply_low;
  // detector restarts over sleep, so ready comes late after wake-up
  always @(posedge mclk) begin
    if (deep_sleep) cnt <= 0;
    else if (cnt < RDY_DLY) cnt <= cnt + 1;
  end
  assign detector_ready_pin = cnt >= RDY_DLY;
endmodule // bvm_analog_model

`default_nettype wire

// File: bench/brownout_vlm_control_regs_tb.sv
// self-checking bench for the monitor register block
`timescale 1ns/1ps
`default_nettype none

module brownout_vlm_control_regs_tb;
  // level 2, slow rate, hold on wake, sleep continuous
  logic [7:0] fuse = 8'h5d;
  localparam logic [7:0] A_CTL = 8'h00, A_THR = 8'h04, A_LVL = 8'h20;
  localparam logic [7:0] A_IE = 8'h24, A_FLG = 8'h28, A_STS = 8'h2c;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic unlock = 1'b0, retire = 1'b0, sleep = 1'b0, low = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, below_pin, ready_pin, strobe, m_act, hold, irq, err;
  logic [1:0] mode, margin;
  logic [2:0] thr;
  int bad_count = 0, n_checks = 0;

  initial forever #50 mclk = ~mclk;

  bvm_ctrl_regs #(.FAST_CYC(17'h00008), .SLOW_CYC(17'h00040)) uut (.mclk(mclk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(err), .detector_config_fuse(fuse),
    .config_change_unlock(unlock), .instr_retired(retire), .deep_sleep(sleep),
    .supply_below_pin(below_pin), .detector_ready_pin(ready_pin), .detector_mode(mode),
    .detector_sample_strobe(strobe), .threshold_code(thr), .monitor_margin_select(margin),
    .monitor_active(m_act), .exec_hold(hold), .supply_early_warning_irq(irq));
  bvm_analog_model u_ana (.mclk(mclk), .deep_sleep(sleep), .supply_low(low),
    .supply_below_pin(below_pin), .detector_ready_pin(ready_pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= 4'hf;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        chk(32'h0, 32'h1, "bus timeout");
        report_and_stop;
      end
      @(posedge mclk);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e}, w);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // unlock key, then k retired instructions
  task key(input int k);
    @(posedge mclk) unlock <= 1'b1;
    @(posedge mclk) unlock <= 1'b0;
    repeat (k) begin
      @(posedge mclk) retire <= 1'b1;
      @(posedge mclk) retire <= 1'b0;
    end
  endtask

  initial begin
    logic x;
    int n;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    wt(4);
    // fuse-loaded and zeroed reset values
    rd(A_CTL, 8'h1d, "mode ctl");
    rd(A_THR, 8'h02, "thr");
    rd(8'h08, 8'h00, "reserved");
    rd(A_LVL, 8'h00, "level");
    rd(A_IE, 8'h00, "ie");
    rd(A_FLG, 8'h00, "flag");
    chk(32'(thr), 32'h2, "thr pin");
    chk(32'(err), 32'h0, "no bus error");
    chk(32'(m_act), 32'h0, "inactive");
    // read-only places ignore writes; sleep field refused without key
    wr(A_THR, 8'hff);
    wr(8'h08, 8'hff);
    wr(A_STS, 8'hff);
    wr(A_CTL, 8'he0);
    rd(A_THR, 8'h02, "thr ro");
    rd(8'h08, 8'h00, "reserved wr");
    rd(A_STS, 8'h00, "sts ro");
    rd(A_CTL, 8'h1d, "ctl locked");
    // last instruction of the window, then one past it
    key(3);
    wr(A_CTL, 8'h00);
    rd(A_CTL, 8'h1c, "ctl win3");
    key(4);
    wr(A_CTL, 8'h02);
    rd(A_CTL, 8'h1c, "ctl win4");
    key(0);
    wr(A_CTL, 8'h02);
    rd(A_CTL, 8'h1e, "ctl sampled");
    for (int c = 0; c < 4; c++) begin
      wr(A_LVL, 8'(c));
      rd(A_LVL, 8'(c), "margin");
      chk(32'(margin), 32'(c), "margin pin");
    end
    // every trigger code against a falling and a rising supply
    for (int g = 0; g < 4; g++) begin
      wr(A_IE, 8'(g * 2 + 1));
      for (int e = 1; e >= 0; e--) begin
        wr(A_FLG, 8'h01);
        wt(1);
        chk(32'(irq), 32'h0, "irq cleared");
        chk(32'(m_act), 32'h1, "monitor on");
        low <= e[0];
        wt(8);
        x = e ? (g == 0 || g == 2) : (g == 1 || g == 2);
        chk(32'(irq), 32'(x), "irq event");
        rd(A_FLG, {7'h0, x}, "flag event");
        rd(A_STS, 8'(e), "status");
      end
    end
    // writing zero keeps the flag; the enable gates the request
    wr(A_IE, 8'h05);
    low <= 1'b1;
    wt(8);
    wr(A_FLG, 8'h00);
    wt(1);
    chk(32'(irq), 32'h1, "flag w0");
    wr(A_IE, 8'h04);
    wt(1);
    chk(32'(irq), 32'h0, "ie off");
    wr(A_IE, 8'h05);
    wt(1);
    chk(32'(irq), 32'h1, "ie on");
    low <= 1'b0;
    wt(8);
    // sampled sleep mode at the slow rate: two strobes per 128 cycles
    sleep <= 1'b1;
    wt(4);
    chk(32'(mode), 32'h2, "sleep mode");
    n = 0;
    repeat (128) begin
      @(posedge mclk);
      if (strobe === 1'b1) n++;
    end
    chk(n, 32'h2, "strobes");
    sleep <= 1'b0;
    wt(3);
    chk(32'(mode), 32'h3, "wake mode");
    chk(32'(hold), 32'h1, "hold");
    wt(30);
    chk(32'(hold), 32'h0, "hold release");
    // reserved sleep code runs as off: flag and status frozen
    key(0);
    wr(A_CTL, 8'h03);
    rd(A_CTL, 8'h1f, "ctl rsvd");
    wr(A_FLG, 8'h01);
    sleep <= 1'b1;
    wt(4);
    chk(32'(mode), 32'h0, "off mode");
    chk(32'(m_act), 32'h0, "off inactive");
    low <= 1'b1;
    wt(10);
    chk(32'(irq), 32'h0, "off irq");
    rd(A_STS, 8'h00, "off status");
    low <= 1'b0;
    wt(10);
    sleep <= 1'b0;
    wt(40);
    chk(32'(irq), 32'h0, "after wake");
    // second reset with a fuse for fast sampled running while awake
    rst <= 1'b1;
    fuse <= 8'h48;
    wt(3);
    rst <= 1'b0;
    wt(4);
    rd(A_CTL, 8'h08, "ctl fuse2");
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      if (strobe === 1'b1) n++;
    end
    chk(n, 32'h8, "fast strobes");
    report_and_stop;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    chk(32'h0, 32'h1, "run timeout");
    report_and_stop;
  end
endmodule // brownout_vlm_control_regs_tb

`default_nettype wire
